//--- design/dctu_defines.svh
// Register offsets, field positions, reset values and timing counts.
// Assumes inclusion by bare name from the timer unit files.
`ifndef DCTU_DEFINES_SVH
`define DCTU_DEFINES_SVH
`define DCTU_ADDR_CTRL      8'h88
`define DCTU_ADDR_MODE      8'h89
`define DCTU_ADDR_C0LO      8'h8A
`define DCTU_ADDR_C1LO      8'h8B
`define DCTU_ADDR_C0HI      8'h8C
`define DCTU_ADDR_C1HI      8'h8D
`define DCTU_ADDR_CLKSEL    8'h8E
`define DCTU_ADDR_IRQCFG    8'h90
`define DCTU_ADDR_IRQEN     8'h91
`define DCTU_ADDR_ACK       8'h92
`define DCTU_BIT_TF1        7
`define DCTU_BIT_TR1        6
`define DCTU_BIT_TF0        5
`define DCTU_BIT_TR0        4
`define DCTU_BIT_IE1        3
`define DCTU_BIT_IT1        2
`define DCTU_BIT_IE0        1
`define DCTU_BIT_IT0        0
`define DCTU_BIT_COUNT1_PIN_GATE      7
`define DCTU_BIT_EVT1       6
`define DCTU_BIT_COUNT0_PIN_GATE      3
`define DCTU_BIT_EVT0       2
`define DCTU_BIT_FAST1      3
`define DCTU_BIT_FAST0      2
`define DCTU_RESET_BYTE     8'h00
`define DCTU_DIV12          12
`define DCTU_DIV4           4
`define DCTU_DIV48          48
`define DCTU_DIV_EXT        8
`endif

//--- design/dctu_pkg.sv
// Types shared by the dual counter timer unit.
// Assumes nothing of its surroundings.
package dctu_pkg;
  typedef enum logic [1:0] {
    DCTU_MODE13  = 2'b00,
    DCTU_MODE16  = 2'b01,
    DCTU_RELOAD8 = 2'b10,
    DCTU_SPLIT   = 2'b11
  } dctu_mode_type;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] mode;
    logic [7:0] clksel;
    logic [7:0] irqcfg;
    logic [7:0] irqen;
    logic [7:0] c0lo;
    logic [7:0] c0hi;
    logic [7:0] c1lo;
    logic [7:0] c1hi;
    logic [5:0] pre_cnt;
    logic [2:0] ext_cnt;
    logic [2:0] sync0;
    logic [2:0] sync1;
    logic [2:0] synci0;
    logic [2:0] synci1;
    logic [2:0] syncx;
    logic       act0_prev;
    logic       act1_prev;
    logic       ov1_pulse;
    logic       ack;
    logic [7:0] rdata;
  } dctu_state_type;
endpackage : dctu_pkg

//--- design/dctu_timer_unit.sv
// Two counter/timers with a classic Wishbone register slave.
// Assumes one system clock; pins are asynchronous and resynchronised here.
`timescale 1ns/10ps
`include "dctu_defines.svh"

// Summary of operation
// - Mode 0 counts thirteen bits: high byte plus low-byte bits four to zero.
// - Thirteen-bit wrap to zero sets the overflow flag and may interrupt.
// - Event select one counts falling edges on the event pin.
// - Fast clock select picks system clock, else the prescaled clock.
// - Counter runs when run bit set and gate off or irq pin active.
// - Setting run never clears or reloads the count.
// - Mode 1 counts all sixteen bits and overflows from all ones.
// - Mode 2 low byte counts and reloads from unchanged high byte.
// - Split mode low byte uses counter 0 controls and flag.
// - Split mode high byte times, runs on run 1, sets flag 1.
// - Counter 1 then counts internally, sets no flag, still outputs overflow.
// - Counter 1 then runs in modes zero to two, stops in mode three.
// - Counter 1 mirrors counter 0 with its own bits and irq pin 1.
// - Overflow flags set by hardware, cleared by writing zero or vectoring.
// - Control register holds run 1 at bit six, run 0 at bit four.
// - Pending flags set by type; vector clear only in edge mode.
// - In level mode pending reads one while pin is active.
// - Type bits two and zero: zero level, one edge.
// - Overflow interrupts only when its enable bit is set.
// - Mode field selects thirteen, sixteen, reload, or split and inactive.
// - Prescale selects divide by twelve, four, forty-eight, or external by eight.
// - Mode register gate and event bits at seven, six, three, two.
// - Clock select bits at three and two, ignored in event mode.
module dctu_timer_unit (
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic       clk_en_i,
  input  wire logic       wb_cyc_i,
  input  wire logic       wb_stb_i,
  input  wire logic       wb_we_i,
  input  wire logic [7:0] wb_adr_i,
  input  wire logic [3:0] wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic            wb_ack_o,
  input  wire logic       count0_event_pin_i,
  input  wire logic       count1_event_pin_i,
  input  wire logic       ext_irq0_pin_i,
  input  wire logic       ext_irq1_pin_i,
  input  wire logic       ext_clock_i,
  input  wire logic       vector_count0_i,
  input  wire logic       vector_count1_i,
  input  wire logic       vector_ext0_i,
  input  wire logic       vector_ext1_i,
  output logic            count0_irq_o,
  output logic            count1_irq_o,
  output logic            ext_irq0_o,
  output logic            ext_irq1_o,
  output logic            count1_overflow_o
);
  import dctu_pkg::*;

  dctu_state_type s_q;
  dctu_state_type s_d;

  // Returns a byte incremented by one, with the carry out in bit eight.
  function automatic logic [8:0] inc8(input logic [7:0] v);
    inc8 = {1'b0, v} + 9'h001;
  endfunction : inc8

  // Advances one byte pair in modes 0 to 2 and reports the overflow.
  function automatic logic [16:0] step_pair(input logic [1:0] md,
                                            input logic [7:0] lo,
                                            input logic [7:0] hi);
    logic [8:0] l;
    logic [8:0] h;
    l = inc8(lo);
    h = inc8(hi);
    step_pair = {1'b0, hi, lo};
    case (md)
      2'b00: begin
        if (lo[4:0] == 5'h1F) begin
          step_pair = {h[8], h[7:0], lo[7:5], 5'h00};
        end else begin
          step_pair = {1'b0, hi, lo[7:5], l[4:0]};
        end
      end
      2'b01: begin
        if (l[8]) begin
          step_pair = {h[8], h[7:0], 8'h00};
        end else begin
          step_pair = {1'b0, hi, l[7:0]};
        end
      end
      2'b10: begin
        if (l[8]) begin
          step_pair = {1'b1, hi, hi};
        end else begin
          step_pair = {1'b0, hi, l[7:0]};
        end
      end
      default: begin
        step_pair = {1'b0, hi, lo};
      end
    endcase
  endfunction : step_pair

  logic        pre_tick;
  logic        fall0;
  logic        fall1;
  logic        act0;
  logic        act1;
  logic        tick0;
  logic        tick1;
  logic        tick_hi;
  logic        run0;
  logic        run1;
  logic        run_hi;
  logic        split;
  logic        ov0;
  logic        ov1;
  logic        ov_hi;
  logic [16:0] r0;
  logic [16:0] r1;
  logic [8:0]  lo_inc;
  logic [8:0]  hi_inc;
  logic        wr;
  logic        rd_hit;
  logic        ext_tick;
  logic        fall_x;
  logic [7:0]  w;
  logic [7:0]  rv;

  always_comb begin
    s_d      = s_q;
    pre_tick = 1'b0;
    ext_tick = 1'b0;
    rv       = 8'h00;
    split    = (s_q.mode[1:0] == DCTU_SPLIT);
    s_d.sync0  = {s_q.sync0[1:0], count0_event_pin_i};
    s_d.sync1  = {s_q.sync1[1:0], count1_event_pin_i};
    s_d.synci0 = {s_q.synci0[1:0], ext_irq0_pin_i};
    s_d.synci1 = {s_q.synci1[1:0], ext_irq1_pin_i};
    s_d.syncx  = {s_q.syncx[1:0], ext_clock_i};
    fall0  = (s_q.sync0[2:1] == 2'b10);
    fall1  = (s_q.sync1[2:1] == 2'b10);
    fall_x = (s_q.syncx[2:1] == 2'b10);
    act0 = s_q.synci0[2] ^ ~s_q.irqcfg[3];
    act1 = s_q.synci1[2] ^ ~s_q.irqcfg[7];
    s_d.act0_prev = act0;
    s_d.act1_prev = act1;
    s_d.pre_cnt = s_q.pre_cnt + 6'h01;
    if (fall_x) begin
      s_d.ext_cnt = s_q.ext_cnt + 3'h1;
      ext_tick    = (s_q.ext_cnt == 3'(`DCTU_DIV_EXT - 1));
    end
    case (s_q.clksel[1:0])
      2'b00: pre_tick = (s_q.pre_cnt >= 6'(`DCTU_DIV12 - 1));
      2'b01: pre_tick = (s_q.pre_cnt >= 6'(`DCTU_DIV4 - 1));
      2'b10: pre_tick = (s_q.pre_cnt >= 6'(`DCTU_DIV48 - 1));
      default: pre_tick = ext_tick;
    endcase
    if (pre_tick || s_q.clksel[1:0] == 2'b11) begin
      s_d.pre_cnt = 6'h00;
    end
    tick0 = s_q.mode[`DCTU_BIT_EVT0] ? fall0 :
            (s_q.clksel[`DCTU_BIT_FAST0] ? 1'b1 : pre_tick);
    tick1 = (s_q.mode[`DCTU_BIT_EVT1] && !split) ? fall1 :
            (s_q.clksel[`DCTU_BIT_FAST1] ? 1'b1 : pre_tick);
    tick_hi = s_q.clksel[`DCTU_BIT_FAST1] ? 1'b1 : pre_tick;
    run0 = s_q.ctrl[`DCTU_BIT_TR0] &&
           (!s_q.mode[`DCTU_BIT_COUNT0_PIN_GATE] || act0);
    run1 = split ? (s_q.mode[5:4] != 2'b11) :
           (s_q.ctrl[`DCTU_BIT_TR1] &&
            (!s_q.mode[`DCTU_BIT_COUNT1_PIN_GATE] || act1) &&
            s_q.mode[5:4] != 2'b11);
    run_hi = s_q.ctrl[`DCTU_BIT_TR1];
    ov0 = 1'b0;
    ov1 = 1'b0;
    ov_hi = 1'b0;
    r0 = step_pair(s_q.mode[1:0], s_q.c0lo, s_q.c0hi);
    r1 = step_pair(s_q.mode[5:4], s_q.c1lo, s_q.c1hi);
    lo_inc = inc8(s_q.c0lo);
    hi_inc = inc8(s_q.c0hi);
    if (clk_en_i && split) begin
      if (run0 && tick0) begin
        s_d.c0lo = lo_inc[7:0];
        ov0      = lo_inc[8];
      end
      if (run_hi && tick_hi) begin
        s_d.c0hi = hi_inc[7:0];
        ov_hi    = hi_inc[8];
      end
    end else if (clk_en_i && run0 && tick0) begin
      s_d.c0lo = r0[7:0];
      s_d.c0hi = r0[15:8];
      ov0      = r0[16];
    end
    if (clk_en_i && run1 && tick1) begin
      s_d.c1lo = r1[7:0];
      s_d.c1hi = r1[15:8];
      ov1      = r1[16];
    end
    s_d.ov1_pulse = ov1;
    // Register slave, one wait state, byte lane zero.
    wr = wb_cyc_i && wb_stb_i && !s_q.ack && wb_we_i && wb_sel_i[0];
    rd_hit = wb_cyc_i && wb_stb_i && !s_q.ack;
    w = wb_dat_i[7:0];
    s_d.ack = rd_hit;
    if (wr) begin
      case (wb_adr_i)
        `DCTU_ADDR_CTRL: s_d.ctrl = w;
        `DCTU_ADDR_MODE: s_d.mode = w;
        `DCTU_ADDR_C0LO: s_d.c0lo = w;
        `DCTU_ADDR_C1LO: s_d.c1lo = w;
        `DCTU_ADDR_C0HI: s_d.c0hi = w;
        `DCTU_ADDR_C1HI: s_d.c1hi = w;
        `DCTU_ADDR_CLKSEL: s_d.clksel = w;
        `DCTU_ADDR_IRQCFG: s_d.irqcfg = w;
        `DCTU_ADDR_IRQEN: s_d.irqen = w;
        default: s_d.ctrl = s_d.ctrl;
      endcase
    end
    if (vector_count0_i) s_d.ctrl[`DCTU_BIT_TF0] = 1'b0;
    if (vector_count1_i) s_d.ctrl[`DCTU_BIT_TF1] = 1'b0;
    if (vector_ext0_i && s_q.ctrl[`DCTU_BIT_IT0]) begin
      s_d.ctrl[`DCTU_BIT_IE0] = 1'b0;
    end
    if (vector_ext1_i && s_q.ctrl[`DCTU_BIT_IT1]) begin
      s_d.ctrl[`DCTU_BIT_IE1] = 1'b0;
    end
    if (ov0) s_d.ctrl[`DCTU_BIT_TF0] = 1'b1;
    if ((ov1 && !split) || ov_hi) s_d.ctrl[`DCTU_BIT_TF1] = 1'b1;
    if (s_q.ctrl[`DCTU_BIT_IT0] ? (act0 && !s_q.act0_prev) : act0) begin
      s_d.ctrl[`DCTU_BIT_IE0] = 1'b1;
    end
    if (s_q.ctrl[`DCTU_BIT_IT1] ? (act1 && !s_q.act1_prev) : act1) begin
      s_d.ctrl[`DCTU_BIT_IE1] = 1'b1;
    end
    case (wb_adr_i)
      `DCTU_ADDR_CTRL: rv = s_q.ctrl;
      `DCTU_ADDR_MODE: rv = s_q.mode;
      `DCTU_ADDR_C0LO: rv = s_q.c0lo;
      `DCTU_ADDR_C1LO: rv = s_q.c1lo;
      `DCTU_ADDR_C0HI: rv = s_q.c0hi;
      `DCTU_ADDR_C1HI: rv = s_q.c1hi;
      `DCTU_ADDR_CLKSEL: rv = s_q.clksel;
      `DCTU_ADDR_IRQCFG: rv = s_q.irqcfg;
      `DCTU_ADDR_IRQEN: rv = s_q.irqen;
      default: rv = 8'h00;
    endcase
    if (rd_hit && !wb_we_i) s_d.rdata = rv;
    if (!clk_en_i) begin
      s_d = s_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      s_q        <= '0;
      s_q.sync0  <= 3'b111;
      s_q.sync1  <= 3'b111;
      s_q.synci0 <= 3'b111;
      s_q.synci1 <= 3'b111;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_dat_o          = {24'h000000, s_q.rdata};
  assign wb_ack_o          = s_q.ack;
  assign count0_irq_o      = s_q.ctrl[`DCTU_BIT_TF0] && s_q.irqen[1];
  assign count1_irq_o      = s_q.ctrl[`DCTU_BIT_TF1] && s_q.irqen[3];
  assign ext_irq0_o        = s_q.ctrl[`DCTU_BIT_IE0] && s_q.irqen[0];
  assign ext_irq1_o        = s_q.ctrl[`DCTU_BIT_IE1] && s_q.irqen[2];
  assign count1_overflow_o = s_q.ov1_pulse;
endmodule : dctu_timer_unit

//--- verification/dctu_pin_model.sv
// Model of the event and interrupt pins at the far side of the timers.
// Assumes the bench calls its tasks; every pin idles high.
`timescale 1ns/10ps
module dctu_pin_model (
  input  wire logic clk_i,
  output logic      evt0_o,
  output logic      evt1_o,
  output logic      irq0_o,
  output logic      irq1_o
);
  initial begin
    evt0_o = 1'b1;
    evt1_o = 1'b1;
    irq0_o = 1'b1;
    irq1_o = 1'b1;
  end

  // Each event is low three clocks and high five, under a quarter rate.
  task automatic pulse(input integer k, input integer n);
    integer j;
    for (j = 0; j < n; j = j + 1) begin
      @(posedge clk_i);
      if (k == 0) evt0_o <= 1'b0;
      else evt1_o <= 1'b0;
      repeat (3) @(posedge clk_i);
      if (k == 0) evt0_o <= 1'b1;
      else evt1_o <= 1'b1;
      repeat (4) @(posedge clk_i);
    end
  endtask : pulse

  task automatic drive_irq(input integer k, input logic v);
    @(posedge clk_i);
    if (k == 0) irq0_o <= v;
    else irq1_o <= v;
    repeat (4) @(posedge clk_i);
  endtask : drive_irq
endmodule : dctu_pin_model

//--- verification/dctu_timer_unit_assertions.sv
// Checker on the ports of the timer unit.
// Assumes a bind to dctu_timer_unit and a single clock.
`timescale 1ns/10ps
module dctu_chk (
  input wire logic        clk_i,
  input wire logic        resetn_i,
  input wire logic        clk_en_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic        vector_count0_i,
  input wire logic        vector_ext0_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        count0_irq_o,
  input wire logic        count1_irq_o,
  input wire logic        ext_irq0_o,
  input wire logic        count1_overflow_o
);
  logic req;
  assign req = wb_cyc_i && wb_stb_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  ack_answer_a: assert property (req && !wb_ack_o && clk_en_i |=> wb_ack_o)
    else $error("request not acked");
  ack_single_a: assert property (wb_ack_o && clk_en_i |=> !wb_ack_o)
    else $error("ack held too long");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(req))
    else $error("ack without request");
  dat_hold_a: assert property (!req |=> $stable(wb_dat_o))
    else $error("read data moved while idle");
  dat_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits set");
  reset_zero_a: assert property ($rose(resetn_i) && $past(clk_en_i) |->
    !wb_ack_o && wb_dat_o == 32'h0 && !count0_irq_o && !count1_irq_o)
    else $error("outputs not cleared by reset");
  flag_clear_a: assert property ($fell(count0_irq_o) && $past(resetn_i) |->
    $past(vector_count0_i || (req && wb_we_i)))
    else $error("overflow flag cleared without cause");
  pend_clear_a: assert property ($fell(ext_irq0_o) && $past(resetn_i) |->
    $past(vector_ext0_i || (req && wb_we_i)))
    else $error("pending flag cleared without cause");
  cover property (count0_irq_o && vector_count0_i);
  cover property (count1_overflow_o);
  cover property (ext_irq0_o && vector_ext0_i);
endmodule : dctu_chk

bind dctu_timer_unit dctu_chk chk (.clk_i, .resetn_i, .clk_en_i, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .vector_count0_i, .vector_ext0_i, .wb_dat_o,
  .wb_ack_o, .count0_irq_o, .count1_irq_o, .ext_irq0_o, .count1_overflow_o);

//--- verification/dctu_timer_unit_tb_top.sv
// Self-checking bench for the dual counter timer unit.
// Assumes the pin model and the checker are compiled before it.
`timescale 1ns/10ps
`include "dctu_defines.svh"
module dctu_timer_unit_tb_top;
  logic        clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic        ext_clk = 1'b0;
  logic        vc0 = 1'b0;
  logic        ve0 = 1'b0;
  logic [31:0] rdat;
  logic        ack, c0i, c1i, e0i, c1o, ev0, ev1, in0, in1;
  logic [31:0] exp_q[$];
  logic [7:0]  d;
  integer      fails = 0;
  integer      checked = 0;
  integer      seed = 63630;
  integer      i;

  always #20 clk_i = ~clk_i;
  initial begin
    #0.3;
    forever #51 ext_clk = ~ext_clk;
  end

  dctu_pin_model pins (.clk_i(clk_i), .evt0_o(ev0), .evt1_o(ev1),
    .irq0_o(in0), .irq1_o(in1));
  dctu_timer_unit dut (.clk_i(clk_i), .resetn_i(resetn_i), .clk_en_i(1'b1),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .count0_event_pin_i(ev0), .count1_event_pin_i(ev1),
    .ext_irq0_pin_i(in0), .ext_irq1_pin_i(in1), .ext_clock_i(ext_clk),
    .vector_count0_i(vc0), .vector_count1_i(1'b0), .vector_ext0_i(ve0),
    .vector_ext1_i(1'b0), .count0_irq_o(c0i), .count1_irq_o(c1i),
    .ext_irq0_o(e0i), .ext_irq1_o(), .count1_overflow_o(c1o));

  task automatic tally_and_finish;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] v);
    integer n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, v};
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n = n + 1;
    end
    if (n == 20) fails = fails + 1;
    if (n == 20) tally_and_finish();
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    bus(1'b0, a, 8'h00);
  endtask : rd

  function automatic logic pick(input integer k);
    case (k)
      0: pick = c0i;
      1: pick = c1i;
      2: pick = e0i;
      default: pick = c1o;
    endcase
  endfunction : pick

  task automatic wait_on(input integer k);
    integer n;
    n = 0;
    while (pick(k) !== 1'b1 && n < 20000) begin
      @(posedge clk_i);
      n = n + 1;
    end
    if (n == 20000) fails = fails + 1;
    if (n == 20000) tally_and_finish();
  endtask : wait_on

  task automatic run_ovf(input logic [7:0] m, h, l, eh);
    bus(1'b1, `DCTU_ADDR_CLKSEL, 8'h04);
    bus(1'b1, `DCTU_ADDR_MODE, m);
    bus(1'b1, `DCTU_ADDR_C0HI, h);
    bus(1'b1, `DCTU_ADDR_C0LO, l);
    bus(1'b1, `DCTU_ADDR_IRQEN, 8'h02);
    bus(1'b1, `DCTU_ADDR_CTRL, 8'h10);
    wait_on(0);
    bus(1'b1, `DCTU_ADDR_CTRL, 8'h20);
    rd(`DCTU_ADDR_CTRL, 8'h20);
    chk({31'h0, c0i}, 32'h1);
    rd(`DCTU_ADDR_C0HI, eh);
    vc0 <= 1'b1;
    @(posedge clk_i);
    vc0 <= 1'b0;
    rd(`DCTU_ADDR_CTRL, 8'h00);
    $display("overflow test done, mode %h", m);
  endtask : run_ovf

  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0) begin
      if (exp_q.size() == 0) chk(rdat, 32'hFFFF_FFFF);
      else chk(rdat, exp_q.pop_front());
    end
  end

  initial begin
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'b1;
    rd(`DCTU_ADDR_CTRL, 8'h00);
    for (i = 0; i < 4; i = i + 1) begin
      d = 8'($random(seed));
      bus(1'b1, 8'h8A + 8'(i), d);
      rd(8'h8A + 8'(i), d);
    end
    bus(1'b1, `DCTU_ADDR_ACK, 8'hFF);
    rd(`DCTU_ADDR_ACK, 8'h00);
    $display("register test done");
    run_ovf(8'h00, 8'hFF, 8'h1E, 8'h00);
    run_ovf(8'h01, 8'hFF, 8'hFE, 8'h00);
    run_ovf(8'h02, 8'hF0, 8'hFE, 8'hF0);
    bus(1'b1, `DCTU_ADDR_MODE, 8'h5D);
    for (i = 0; i < 4; i = i + 1) bus(1'b1, 8'h8A + 8'(i), 8'h00);
    bus(1'b1, `DCTU_ADDR_CTRL, 8'h10);
    pins.pulse(0, 3);
    rd(`DCTU_ADDR_C0LO, 8'h00);
    pins.drive_irq(0, 1'b0);
    pins.pulse(0, 5);
    rd(`DCTU_ADDR_C0LO, 8'h05);
    bus(1'b1, `DCTU_ADDR_CTRL, 8'h50);
    pins.pulse(1, 4);
    rd(`DCTU_ADDR_C1LO, 8'h04);
    $display("event test done");
    bus(1'b1, `DCTU_ADDR_IRQEN, 8'h01);
    wait_on(2);
    chk({31'h0, e0i}, 32'h1);
    pins.drive_irq(0, 1'b1);
    bus(1'b1, `DCTU_ADDR_CTRL, 8'h01);
    pins.drive_irq(0, 1'b0);
    wait_on(2);
    ve0 <= 1'b1;
    @(posedge clk_i);
    ve0 <= 1'b0;
    rd(`DCTU_ADDR_CTRL, 8'h01);
    pins.drive_irq(0, 1'b1);
    $display("pin interrupt test done");
    bus(1'b1, `DCTU_ADDR_CLKSEL, 8'h0C);
    bus(1'b1, `DCTU_ADDR_MODE, 8'h03);
    bus(1'b1, `DCTU_ADDR_C0HI, 8'hFE);
    bus(1'b1, `DCTU_ADDR_IRQEN, 8'h08);
    bus(1'b1, `DCTU_ADDR_CTRL, 8'h40);
    wait_on(1);
    rd(`DCTU_ADDR_CTRL, 8'hC0);
    bus(1'b1, `DCTU_ADDR_CTRL, 8'h00);
    wait_on(3);
    rd(`DCTU_ADDR_CTRL, 8'h00);
    $display("split test done");
    tally_and_finish();
  end
endmodule : dctu_timer_unit_tb_top
